//--- bench/scrr_sink.sv
// Transport-side byte sink that takes the parameter stream and records it
`timescale 1ns/1ps
`default_nettype none

module scrr_sink (
  input wire logic pclk, // Device clock
  input wire logic presetn, // Async reset, active low
  input wire logic tx_valid, // Byte offered
  input wire logic [7:0] tx_data, // Offered byte
  input wire logic tx_last, // Final byte flag
  input wire logic slow, // Stall every other cycle when high
  output logic tx_ready // Sink takes the byte
);
  logic [7:0] mem [0:63];
  int n;
  int last_at;
  logic ph_r;
  // Capture a byte on each handshake edge, toggle readiness when stalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n <= 0;
      last_at <= -1;
      ph_r <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        mem[n[5:0]] <= tx_data;
        if (tx_last) last_at <= n;
        n <= n + 1;
      end
      ph_r <= ~ph_r;
      tx_ready <= slow ? ph_r : 1'b1;
    end
  end
endmodule : scrr_sink
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the capability report responder
`timescale 1ns/1ps
`default_nettype none
`include "scrr_regs.svh"

module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic slow = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_valid, tx_last, tx_ready, cmd_done, cmd_check, re;
  logic [7:0] tx_data;
  logic [31:0] rv;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int base;
  logic [95:0] bad [0:8] = '{96'ha40d_0000_0000_0000_0004_0000, 96'ha30e_0000_0000_0000_0004_0000,
    96'ha32d_0000_0000_0000_0004_0000, 96'ha30d_0100_0000_0000_0004_0000,
    96'ha30d_0000_0080_0000_0004_0000, 96'ha30d_0000_0000_0000_0004_0100,
    96'ha30d_0000_0000_0000_0004_0080, 96'ha30d_0000_0000_0000_0004_0004,
    96'ha30d_0000_0000_0000_0003_0000};
  logic [7:0] basc [0:8] = '{8'h20, 8'h20, 8'h20, 8'h24, 8'h24, 8'h24, 8'h24, 8'h24, 8'h24};
  logic [31:0] dc [0:10] = '{32'h2a00_043b, 32'h2a00_053b, 32'h2a00_063b, 32'h2a00_073b,
    32'h2a00_0f3b, 32'h2a00_0e3b, 32'h2a02_0e3b, 32'h2a00_033b, 32'h2a01_0028,
    32'h2a04_0028, 32'h0000_043b};
  logic [7:0] ecs [0:10] = '{8'h2a, 8'h2a, 8'h2a, 8'h2a, 8'h2a, 8'h00, 8'h2a, 8'h00, 8'h2a,
    8'h00, 8'h00};

  scrr_top scrr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .cmd_done(cmd_done), .cmd_check(cmd_check));
  scrr_sink scrr_sink_i (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .slow(slow), .tx_ready(tx_ready));

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  // Cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("mismatches %0d of %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Load CDB bytes 0..11, byte 0 in the top of the vector
  task automatic put_cdb(input logic [95:0] cdb);
    for (int w = 0; w < 3; w++) begin
      apb(1'b1, 12'h004 + 12'(4 * w), {cdb[95 - 32 * w - 24 -: 8], cdb[95 - 32 * w - 16 -: 8],
        cdb[95 - 32 * w - 8 -: 8], cdb[95 - 32 * w -: 8]});
    end
  endtask : put_cdb

  // Start a command and wait for its completion pulse
  task automatic go(input logic [31:0] ctl);
    int k;
    k = 0;
    base = scrr_sink_i.n;
    apb(1'b1, `SCRR_CTRL_OFS, ctl);
    do begin
      @(posedge pclk);
      k++;
    end while (cmd_done !== 1'b1 && k < 200);
    check("cmd_done", {31'h0, cmd_done}, 32'h1);
  endtask : go

  // Compare the recorded stream with the expected bytes
  task automatic bytes(input logic [95:0] exp, input int cnt);
    check("count", 32'(scrr_sink_i.n - base), 32'(cnt));
    check("last", 32'(scrr_sink_i.last_at), 32'(base + cnt - 1));
    for (int k = 0; k < cnt; k++) begin
      check("byte", {24'h0, scrr_sink_i.mem[6'(base + k)]},
        {24'h0, exp[95 - 8 * k -: 8]});
    end
  endtask : bytes

  // Task-management report with a given support map and allocation length
  task automatic tmf(input logic [8:0] sup, input logic [31:0] alen);
    apb(1'b1, `SCRR_TMFSUP_OFS, {23'h0, sup});
    put_cdb({64'ha30d_0000_0000_0000 | 64'(alen[31:16]),
      alen[15:0], 16'h0000});
    go(32'h0000_0001);
    apb(1'b0, `SCRR_ALLOC_OFS, 32'h0);
    check("alloc", rv, alen);
    apb(1'b0, `SCRR_STATUS_OFS, 32'h0);
    check("good", {29'h0, rv[2:0]}, 32'h4);
    bytes({sup[8:3], 2'b00, 5'h00, sup[2:0], 80'h0}, 4);
  endtask : tmf

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SCRR_STATUS_OFS, 32'h0);
    check("status_rst", rv, 32'h0);
    check("mapped_ok", {31'h0, re}, 32'h0);
    check("pready", {31'h0, pready}, 32'h1);
    apb(1'b0, `SCRR_TMFSUP_OFS, 32'h0);
    check("tmfsup_rst", rv, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    check("unmapped_err", {31'h0, re}, 32'h1);
    check("unmapped_data", rv, 32'h0);
    slow <= 1'b1;
    tmf(9'h1a5, 32'h0000_0004);
    tmf(9'h05a, 32'h0100_0002);
    // Both start bits set: the report start wins, map 05a again
    go(32'h0000_0003);
    bytes({8'h2c, 8'h02, 80'h0}, 4);
    // Malformed commands end in check condition with no data
    for (int i = 0; i < 9; i++) begin
      put_cdb(bad[i]);
      go(32'h0000_0001);
      apb(1'b0, `SCRR_STATUS_OFS, 32'h0);
      check("sense", {rv[23:16], rv[11:8], 1'b0, rv[2:0]},
        {basc[i], 4'h5, 4'h2});
      check("cmd_check", {31'h0, cmd_check}, 32'h1);
      check("no_data", 32'(scrr_sink_i.n - base), 32'h0);
    end
    // Timeouts descriptor for each command-specific case
    apb(1'b1, `SCRR_NOMRAW_OFS, 32'h1020_3040);
    apb(1'b1, `SCRR_RECRAW_OFS, 32'h5060_7080);
    apb(1'b1, `SCRR_EXTDLY_OFS, 32'h0000_0040);
    apb(1'b1, `SCRR_PWRDLY_OFS, 32'h0000_1000);
    for (int i = 0; i < 11; i++) begin
      slow <= i[0];
      apb(1'b1, `SCRR_DCMD_OFS, dc[i]);
      go(32'h0000_0002);
      check("check_clr", {31'h0, cmd_check}, 32'h0);
      bytes({16'h000a, 8'h00,
        ecs[i], 32'h1020_3000 - (dc[i][18] ? 32'h1000 : 32'h0),
        32'h5060_7040 - (dc[i][18] ? 32'h1000 : 32'h0)}, 12);
      check("cs", {24'h0, scrr_sink_i.mem[6'(base + 3)]},
        {24'h0, ecs[i]});
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

//--- common/scrr_pkg.sv
// Types shared by the report responder
package scrr_pkg;
  // Command sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_DECODE = 4'h2,
    S_SEND = 4'h4,
    S_DONE = 4'h8
  } scrr_state_e;
  typedef logic [7:0] scrr_byte_t;
endpackage : scrr_pkg

//--- common/scrr_regs.svh
// Register offsets, field positions, reset values and fixed codes of the report responder
`ifndef SCRR_REGS_SVH
`define SCRR_REGS_SVH

// Register byte addresses
`define SCRR_CTRL_OFS 12'h000
`define SCRR_CDB0_OFS 12'h004
`define SCRR_CDB1_OFS 12'h008
`define SCRR_CDB2_OFS 12'h00c
`define SCRR_DCMD_OFS 12'h010
`define SCRR_NOMRAW_OFS 12'h014
`define SCRR_RECRAW_OFS 12'h018
`define SCRR_EXTDLY_OFS 12'h01c
`define SCRR_PWRDLY_OFS 12'h020
`define SCRR_TMFSUP_OFS 12'h024
`define SCRR_STATUS_OFS 12'h028
`define SCRR_ALLOC_OFS 12'h02c

// CTRL fields (write-one pulses)
`define SCRR_CTRL_TMF_BIT 0
`define SCRR_CTRL_CTD_BIT 1

// DCMD fields
`define SCRR_DCMD_OP_LSB 0
`define SCRR_DCMD_MODE_LSB 8
`define SCRR_DCMD_CSDEF_BIT 16
`define SCRR_DCMD_OTHEVT_BIT 17
`define SCRR_DCMD_PWRCHG_BIT 18
`define SCRR_DCMD_SECS_LSB 24

// STATUS fields
`define SCRR_ST_BUSY_BIT 0
`define SCRR_ST_CHECK_BIT 1
`define SCRR_ST_GOOD_BIT 2
`define SCRR_ST_SK_LSB 8
`define SCRR_ST_ASC_LSB 16

// Reset values
`define SCRR_TMFSUP_RST 9'h000
`define SCRR_WORD_RST 32'h0000_0000

// Command and descriptor codes
`define SCRR_OP_REPORT 8'ha3
`define SCRR_SA_TMF 5'h0d
`define SCRR_OP_WRBUF 8'h3b
`define SCRR_WB_DL_FIRST 8'h04
`define SCRR_WB_DL_LAST 8'h07
`define SCRR_WB_DEFER 8'h0e
`define SCRR_WB_ACTIVATE 8'h0f
`define SCRR_DESC_LEN 8'h0a
`define SCRR_DESC_BYTES 4'hc
`define SCRR_TMF_BYTES 4'h4
`define SCRR_MIN_ALLOC 32'h0000_0004
`define SCRR_SK_ILLEGAL 4'h5
`define SCRR_ASC_BAD_FIELD 8'h24
`define SCRR_ASC_BAD_OP 8'h20

`endif

//--- hw/scrr_top.sv
// Capability report responder: task-management report and command timeouts descriptor
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scrr_regs.svh"

module scrr_top (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic tx_valid, // Parameter byte valid
  output logic [7:0] tx_data, // Parameter byte
  output logic tx_last, // Final byte of the transfer
  input wire logic tx_ready, // Transport takes the byte
  output logic cmd_done, // Command finished pulse
  output logic cmd_check // Last command ended in check condition
);

  scrr_pkg::scrr_state_e state_r, state_nxt;
  logic [31:0] cdb0_r, cdb1_r, cdb2_r, dcmd_r, nomraw_r, recraw_r, extdly_r, pwrdly_r;
  logic [8:0] tmfsup_r;
  logic [31:0] prdata_r;
  scrr_pkg::scrr_byte_t resp_r [0:11];
  logic [3:0] len_r, cnt_r;
  logic is_tmf_r, check_r, good_r;
  logic [3:0] sk_r;
  logic [7:0] asc_r;
  logic done_r;
  logic wr_en, rd_setup, mapped, start_tmf, start_ctd;
  logic [31:0] alloc_len;
  logic op_ok, fld_ok, short_alloc;
  logic [31:0] nom_val, rec_val, pwr_sub;
  logic [7:0] cs_val;

  // Address decode shared by reads and writes
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a <= `SCRR_ALLOC_OFS) && (a[1:0] == 2'b00);
  endfunction : addr_hit

  // Saturating subtraction of an excluded interval
  function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
    sat_sub = (a > b) ? (a - b) : 32'h0000_0000;
  endfunction : sat_sub

  // Command-specific byte of the timeouts descriptor
  function automatic logic [7:0] cs_byte(input logic [31:0] d);
    logic [7:0] op;
    logic [7:0] md;
    logic [7:0] secs;
    op = d[`SCRR_DCMD_OP_LSB +: 8];
    md = d[`SCRR_DCMD_MODE_LSB +: 8];
    secs = d[`SCRR_DCMD_SECS_LSB +: 8];
    if (op == `SCRR_OP_WRBUF) begin
      if ((md >= `SCRR_WB_DL_FIRST && md <= `SCRR_WB_DL_LAST) || md == `SCRR_WB_ACTIVATE) begin
        cs_byte = secs;
      end else if (md == `SCRR_WB_DEFER && d[`SCRR_DCMD_OTHEVT_BIT]) begin
        cs_byte = secs;
      end else begin
        cs_byte = 8'h00;
      end
    end else if (d[`SCRR_DCMD_CSDEF_BIT]) begin
      cs_byte = secs;
    end else begin
      cs_byte = 8'h00;
    end
  endfunction : cs_byte

  // APB strobes; zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = addr_hit(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;
  assign start_tmf = wr_en && mapped && (paddr == `SCRR_CTRL_OFS) && pwdata[`SCRR_CTRL_TMF_BIT]
                     && (state_r == scrr_pkg::S_IDLE);
  assign start_ctd = wr_en && mapped && (paddr == `SCRR_CTRL_OFS) && pwdata[`SCRR_CTRL_CTD_BIT]
                     && (state_r == scrr_pkg::S_IDLE) && !start_tmf;

  // CDB decode
  assign alloc_len = {cdb1_r[23:16], cdb1_r[31:24], cdb2_r[7:0], cdb2_r[15:8]};
  assign op_ok = (cdb0_r[7:0] == `SCRR_OP_REPORT) && (cdb0_r[12:8] == `SCRR_SA_TMF)
                 && (cdb0_r[15:13] == 3'b000);
  assign fld_ok = (cdb0_r[31:16] == 16'h0000) && (cdb1_r[15:0] == 16'h0000)
                  && (cdb2_r[23:16] == 8'h00) && (cdb2_r[31:30] == 2'b00)
                  && !cdb2_r[26];
  assign short_alloc = alloc_len < `SCRR_MIN_ALLOC;

  // Timeouts net of uncontrolled delays and power transition
  assign pwr_sub = dcmd_r[`SCRR_DCMD_PWRCHG_BIT] ? pwrdly_r : `SCRR_WORD_RST;
  assign nom_val = sat_sub(sat_sub(nomraw_r, extdly_r), pwr_sub);
  assign rec_val = sat_sub(sat_sub(recraw_r, extdly_r), pwr_sub);
  assign cs_val = cs_byte(dcmd_r);

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdb0_r <= `SCRR_WORD_RST;
      cdb1_r <= `SCRR_WORD_RST;
      cdb2_r <= `SCRR_WORD_RST;
      dcmd_r <= `SCRR_WORD_RST;
      nomraw_r <= `SCRR_WORD_RST;
      recraw_r <= `SCRR_WORD_RST;
      extdly_r <= `SCRR_WORD_RST;
      pwrdly_r <= `SCRR_WORD_RST;
      tmfsup_r <= `SCRR_TMFSUP_RST;
    end else if (wr_en) begin
      case (paddr)
        `SCRR_CDB0_OFS: cdb0_r <= pwdata;
        `SCRR_CDB1_OFS: cdb1_r <= pwdata;
        `SCRR_CDB2_OFS: cdb2_r <= pwdata;
        `SCRR_DCMD_OFS: dcmd_r <= pwdata;
        `SCRR_NOMRAW_OFS: nomraw_r <= pwdata;
        `SCRR_RECRAW_OFS: recraw_r <= pwdata;
        `SCRR_EXTDLY_OFS: extdly_r <= pwdata;
        `SCRR_PWRDLY_OFS: pwrdly_r <= pwdata;
        `SCRR_TMFSUP_OFS: tmfsup_r <= pwdata[8:0];
        default: ;
      endcase
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= `SCRR_WORD_RST;
    end else if (rd_setup) begin
      case (paddr)
        `SCRR_CDB0_OFS: prdata_r <= cdb0_r;
        `SCRR_CDB1_OFS: prdata_r <= cdb1_r;
        `SCRR_CDB2_OFS: prdata_r <= cdb2_r;
        `SCRR_DCMD_OFS: prdata_r <= dcmd_r;
        `SCRR_NOMRAW_OFS: prdata_r <= nomraw_r;
        `SCRR_RECRAW_OFS: prdata_r <= recraw_r;
        `SCRR_EXTDLY_OFS: prdata_r <= extdly_r;
        `SCRR_PWRDLY_OFS: prdata_r <= pwrdly_r;
        `SCRR_TMFSUP_OFS: prdata_r <= {23'h000000, tmfsup_r};
        `SCRR_STATUS_OFS: prdata_r <= {8'h00, asc_r, 4'h0, sk_r, 5'h00, good_r, check_r,
                                       (state_r != scrr_pkg::S_IDLE)};
        `SCRR_ALLOC_OFS: prdata_r <= alloc_len;
        default: prdata_r <= `SCRR_WORD_RST;
      endcase
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      scrr_pkg::S_IDLE: begin
        if (start_tmf) begin
          state_nxt = scrr_pkg::S_DECODE;
        end else if (start_ctd) begin
          state_nxt = scrr_pkg::S_SEND;
        end
      end
      scrr_pkg::S_DECODE: begin
        state_nxt = (op_ok && fld_ok && !short_alloc) ? scrr_pkg::S_SEND : scrr_pkg::S_DONE;
      end
      scrr_pkg::S_SEND: begin
        if (tx_ready && (cnt_r == len_r - 4'h1)) begin
          state_nxt = scrr_pkg::S_DONE;
        end
      end
      scrr_pkg::S_DONE: state_nxt = scrr_pkg::S_IDLE;
      default: state_nxt = scrr_pkg::S_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= scrr_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Completion status and sense data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_r <= 1'b0;
      good_r <= 1'b0;
      sk_r <= 4'h0;
      asc_r <= 8'h00;
      is_tmf_r <= 1'b0;
    end else if (start_tmf || start_ctd) begin
      check_r <= 1'b0;
      good_r <= 1'b0;
      sk_r <= 4'h0;
      asc_r <= 8'h00;
      is_tmf_r <= start_tmf;
    end else if (state_r == scrr_pkg::S_DECODE) begin
      if (!op_ok) begin
        check_r <= 1'b1;
        sk_r <= `SCRR_SK_ILLEGAL;
        asc_r <= `SCRR_ASC_BAD_OP;
      end else if (!fld_ok || short_alloc) begin
        check_r <= 1'b1;
        sk_r <= `SCRR_SK_ILLEGAL;
        asc_r <= `SCRR_ASC_BAD_FIELD;
      end
    end else if (state_r == scrr_pkg::S_SEND && state_nxt == scrr_pkg::S_DONE) begin
      good_r <= 1'b1;
    end
  end

  // Response bytes: built at start, shifted out MSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 12; i++) begin
        resp_r[i] <= 8'h00;
      end
    end else if (start_ctd) begin
      resp_r[0] <= 8'h00;
      resp_r[1] <= `SCRR_DESC_LEN;
      resp_r[2] <= 8'h00;
      resp_r[3] <= cs_val;
      for (int i = 0; i < 4; i++) begin
        resp_r[4 + i] <= nom_val[31 - 8 * i -: 8];
        resp_r[8 + i] <= rec_val[31 - 8 * i -: 8];
      end
    end else if (start_tmf) begin
      resp_r[0] <= {tmfsup_r[8:3], 2'b00};
      resp_r[1] <= {5'h00, tmfsup_r[2:0]};
      for (int i = 2; i < 12; i++) begin
        resp_r[i] <= 8'h00;
      end
    end else if (state_r == scrr_pkg::S_SEND && tx_ready) begin
      for (int i = 0; i < 11; i++) begin
        resp_r[i] <= resp_r[i + 1];
      end
      resp_r[11] <= 8'h00;
    end
  end

  // Byte count and truncated length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r <= 4'h0;
      cnt_r <= 4'h0;
    end else if (start_ctd) begin
      len_r <= `SCRR_DESC_BYTES;
      cnt_r <= 4'h0;
    end else if (start_tmf) begin
      len_r <= `SCRR_TMF_BYTES;
      cnt_r <= 4'h0;
    end else if (state_r == scrr_pkg::S_DECODE) begin
      if (alloc_len < {28'h0000000, `SCRR_TMF_BYTES}) begin
        len_r <= alloc_len[3:0];
      end
    end else if (state_r == scrr_pkg::S_SEND && tx_ready) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Completion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == scrr_pkg::S_DONE);
    end
  end

  // Stream and status outputs
  assign tx_valid = (state_r == scrr_pkg::S_SEND);
  assign tx_data = resp_r[0];
  assign tx_last = tx_valid && (cnt_r == len_r - 4'h1);
  assign cmd_done = done_r;
  assign cmd_check = check_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_tmf_start;
    start_tmf;
  endsequence
  sequence seq_decode_bad;
    ##1 (state_r == scrr_pkg::S_DECODE) && op_ok && (!fld_ok || short_alloc);
  endsequence

  chk_short_alloc: assert property (seq_tmf_start ##0 seq_decode_bad |=> ##1
    check_r && sk_r == `SCRR_SK_ILLEGAL && asc_r == `SCRR_ASC_BAD_FIELD && !tx_valid)
    else $error("short allocation not refused");
  chk_len_bound: assert property (tx_valid |-> cnt_r < len_r)
    else $error("byte count beyond allowed length");
  chk_desc_len: assert property (start_ctd |=> tx_data == 8'h00 && resp_r[1] == 8'h0a)
    else $error("descriptor length bytes wrong");
  chk_desc_rsvd: assert property (start_ctd |=> resp_r[2] == 8'h00 && len_r == 4'hc)
    else $error("descriptor reserved byte or length wrong");
  chk_wb_rsvd: assert property (start_ctd && dcmd_r[7:0] == 8'h3b
    && (dcmd_r[15:8] < 8'h04 || (dcmd_r[15:8] > 8'h07 && dcmd_r[15:8] < 8'h0e))
    |=> resp_r[3] == 8'h00)
    else $error("command-specific byte not reserved");
  chk_nom_msb: assert property (start_ctd |=> resp_r[4] == $past(nom_val[31:24]))
    else $error("nominal timeout not msb first");
  chk_tmf_map: assert property (start_tmf |=> resp_r[1][7:3] == 5'h00
    && resp_r[2] == 8'h00 && resp_r[0][7:2] == $past(tmfsup_r[8:3]) && resp_r[0][1:0] == 2'b00)
    else $error("support map layout wrong");
  chk_op_decode: assert property ((state_r == scrr_pkg::S_DECODE)
    && (cdb0_r[7:0] != 8'ha3) |=> state_r == scrr_pkg::S_DONE ##1 cmd_done && check_r)
    else $error("unknown opcode accepted");
  chk_last_flag: assert property (tx_valid && tx_ready && tx_last |=> state_r == scrr_pkg::S_DONE)
    else $error("last byte did not end transfer");

  // Refused commands stay silent, report length fixed, completion is one pulse
  chk_check_quiet: assert property (check_r |-> !tx_valid)
    else $error("data sent after check condition");
  chk_cs_reserved: assert property (start_ctd && dcmd_r[7:0] != 8'h3b && !dcmd_r[16]
    |=> resp_r[3] == 8'h00)
    else $error("undefined command-specific byte not zero");
  chk_tmf_len: assert property (tx_valid && is_tmf_r |-> len_r == `SCRR_TMF_BYTES)
    else $error("support map length not four bytes");
  chk_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("completion pulse longer than one cycle");

endmodule : scrr_top
`default_nettype wire
